// file: design/hbridge_protection_output_control.sv
// protection, fault latching and output control of the h-bridge driver
`timescale 1ns/1ps
`default_nettype none
module hbridge_protection_output_control
  import hbridge_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // control pins
  input  wire logic        disable_pin,
  input  wire logic        sleep_release_input,
  input  wire logic        input_one,
  input  wire logic        input_two,
  // comparator inputs
  input  wire logic        supply_low_cmp,
  input  wire logic        supply_high_cmp,
  input  wire logic        temp_warn_cmp,
  input  wire logic        temp_shut_cmp,
  input  wire logic        short_a_cmp,
  input  wire logic        short_b_cmp,
  // bridge outputs
  output logic             bridge_output_a,
  output logic             bridge_output_a_oe,
  output logic             bridge_output_b,
  output logic             bridge_output_b_oe,
  output logic             fault_status_n
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------

  // byte-lane merge of a write into a register image
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    return res;
  endfunction : lane_merge

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------

  logic              rst_s1_r;
  logic              rst_s2_r;
  logic              rst_int_n;
  logic [PIN_W-1:0]  pin_s1_r;
  logic [PIN_W-1:0]  pin_s2_r;
  logic [PIN_W-1:0]  pin_raw;

  // async assert, two-stage release
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  assign rst_int_n = rst_s2_r;

  assign pin_raw = {short_b_cmp, short_a_cmp, temp_shut_cmp, temp_warn_cmp,
                    supply_high_cmp, supply_low_cmp, input_two, input_one,
                    sleep_release_input, disable_pin};

  // R13 floating-pin levels at reset
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      pin_s1_r <= PIN_RST;
      pin_s2_r <= PIN_RST;
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // detector filters
  // ---------------------------------------------------------------

  det_if uv_det ();
  det_if ov_det ();
  det_if ot_det ();

  assign uv_det.raw = pin_s2_r[PIN_UV];
  assign ov_det.raw = pin_s2_r[PIN_OV];
  assign ot_det.raw = pin_s2_r[PIN_OT];

  // R1 uv filter
  det_filter #(.TERM(UV_FILT_CYC)) uv_filt (
    .core_clk (core_clk),
    .rst_n    (rst_int_n),
    .det      (uv_det.flt)
  );

  // R3 ov filter
  det_filter #(.TERM(OV_FILT_CYC)) ov_filt (
    .core_clk (core_clk),
    .rst_n    (rst_int_n),
    .det      (ov_det.flt)
  );

  // R8 ot filter
  det_filter #(.TERM(OT_FILT_CYC)) ot_filt (
    .core_clk (core_clk),
    .rst_n    (rst_int_n),
    .det      (ot_det.flt)
  );

  // ---------------------------------------------------------------
  // registers and bus decode
  // ---------------------------------------------------------------

  logic [4:0]  ctrl_r;
  logic [12:0] mask_r;
  logic [12:0] stat_r;
  logic [12:0] stat_nxt;
  logic [12:0] stat_set;
  logic [12:0] clr_bits;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic        bus_req;
  logic        wr_ctrl;
  logic        wr_mask;
  logic        wr_stat;
  logic [31:0] clr_word;
  logic [31:0] live_word;
  logic [31:0] ctrl_merged;
  logic [31:0] mask_merged;

  assign bus_req  = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_ctrl  = bus_req && wb_we_i && (wb_adr_i == CTRL_OFS);
  assign wr_mask  = bus_req && wb_we_i && (wb_adr_i == MASK_OFS);
  assign wr_stat  = bus_req && wb_we_i && (wb_adr_i == STAT_OFS);
  assign clr_word = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
  assign clr_bits = wr_stat ? (clr_word[12:0] & STAT_BITS) : 13'h0000;
  // write images of the writable registers, lanes merged
  assign ctrl_merged = lane_merge({27'h0, ctrl_r}, wb_dat_i, wb_sel_i);
  assign mask_merged = lane_merge({19'h0, mask_r}, wb_dat_i, wb_sel_i);

  // one-cycle acknowledge for every address
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
      ack_r <= 1'b0;
    else
      ack_r <= bus_req;
  end

  // R15 control register with soft inputs
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
      ctrl_r <= CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= ctrl_merged[4:0] & CTRL_WMASK;
  end

  // R17 mask register, same layout as status
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
      mask_r <= MASK_RST;
    else if (wr_mask)
      mask_r <= mask_merged[12:0] & MASK_WMASK;
  end

  // ---------------------------------------------------------------
  // control decode
  // ---------------------------------------------------------------

  logic dis_s;
  logic awake_s;
  logic dis_d_r;
  logic awake_d_r;
  logic pin_toggle;
  logic full_mode;
  logic ov_force;
  logic in_a;
  logic in_b;
  logic drive_ok;
  logic off_a_r;
  logic off_b_r;
  logic sc_a;
  logic sc_b;
  logic release_latch;

  assign dis_s     = pin_s2_r[PIN_DIS];
  assign awake_s   = pin_s2_r[PIN_SLEEP];
  assign full_mode = ctrl_r[CTRL_FULL];
  assign sc_a      = pin_s2_r[PIN_SC_A];
  assign sc_b      = pin_s2_r[PIN_SC_B];

  // edge history for latch release
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      dis_d_r   <= PIN_RST[PIN_DIS];
      awake_d_r <= PIN_RST[PIN_SLEEP];
    end
    else
    begin
      dis_d_r   <= dis_s;
      awake_d_r <= awake_s;
    end
  end

  // R9 release on pin toggle or clear write
  assign pin_toggle    = (dis_s != dis_d_r) || (awake_s != awake_d_r);
  assign release_latch = pin_toggle || (|(clr_bits & STAT_BITS
                         & ((13'h0001 << ST_OT) | (13'h0001 << ST_SHORT_A) | (13'h0001 << ST_SHORT_B))));

  // ---------------------------------------------------------------
  // fault flags
  // ---------------------------------------------------------------

  // sticky set sources; warning bit is live only
  always_comb
  begin
    stat_set             = 13'h0000;
    stat_set[ST_UV]      = uv_det.qual;
    stat_set[ST_OV]      = ov_det.qual;
    stat_set[ST_OT]      = ot_det.qual;
    stat_set[ST_SHORT_A] = sc_a;
    stat_set[ST_SHORT_B] = sc_b;
  end

  // R2 R6 R8 flags latch until cleared, set wins
  always_comb
  begin
    stat_nxt = stat_r & ~clr_bits;
    if (pin_toggle)
    begin
      stat_nxt[ST_OT]      = 1'b0;
      stat_nxt[ST_SHORT_A] = 1'b0;
      stat_nxt[ST_SHORT_B] = 1'b0;
    end
    stat_nxt = stat_nxt | stat_set;
    // R7 live warning
    stat_nxt[ST_TW] = pin_s2_r[PIN_TW];
  end

  // R21 flags cleared at reset
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
      stat_r <= 13'h0000;
    else
      stat_r <= stat_nxt;
  end

  // R8 R9 R10 latched outputs off, set wins over release
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      off_a_r <= 1'b0;
      off_b_r <= 1'b0;
    end
    else
    begin
      off_a_r <= (off_a_r && !release_latch) || ot_det.qual || sc_a || (full_mode && sc_b);
      off_b_r <= (off_b_r && !release_latch) || ot_det.qual || sc_b || (full_mode && sc_a);
    end
  end

  // ---------------------------------------------------------------
  // output truth table
  // ---------------------------------------------------------------

  // R15 pin or soft input source
  assign in_a = ctrl_r[CTRL_SRC_SEL] ? ctrl_r[CTRL_SOFT_A] : pin_s2_r[PIN_IN1];
  assign in_b = ctrl_r[CTRL_SRC_SEL] ? ctrl_r[CTRL_SOFT_B] : pin_s2_r[PIN_IN2];

  // R4 R5 R18 R19 full-bridge overvoltage braking
  assign ov_force = full_mode && ov_det.qual && !mask_r[MASK_DOV];

  // R14 R2 drive permission
  assign drive_ok = ctrl_r[CTRL_EN] && awake_s && !uv_det.qual && (!dis_s || ov_force);

  // registered output levels and enables
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      bridge_output_a    <= 1'b0;
      bridge_output_b    <= 1'b0;
      bridge_output_a_oe <= 1'b0;
      bridge_output_b_oe <= 1'b0;
    end
    else
    begin
      bridge_output_a_oe <= drive_ok && !off_a_r;
      bridge_output_b_oe <= drive_ok && !off_b_r;
      if (ov_force)
      begin
        bridge_output_a <= 1'b1;
        bridge_output_b <= 1'b1;
      end
      else if (!full_mode)
      begin
        // R11 independent half bridges
        bridge_output_a <= in_a;
        bridge_output_b <= in_b;
      end
      else
      begin
        // R12 full bridge decode
        bridge_output_a <= in_a || !in_b;
        bridge_output_b <= !in_a || !in_b;
      end
    end
  end

  // R16 R17 status pin: sleep high, disable low, else masked faults
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
      fault_status_n <= 1'b1;
    else if (!awake_s)
      fault_status_n <= 1'b1;
    else
      fault_status_n <= !(dis_s || (|(stat_r & mask_r & STAT_BITS)));
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------

  assign live_word = {20'h0, off_b_r, off_a_r, pin_s2_r[PIN_SC_B:PIN_IN1],
                      awake_s, dis_s};

  // read data registered with the acknowledge, unmapped reads zero
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
      rdata_r <= 32'h0000_0000;
    else if (bus_req && !wb_we_i)
      unique case (wb_adr_i)
        CTRL_OFS: rdata_r <= {27'h0, ctrl_r};
        MASK_OFS: rdata_r <= {19'h0, mask_r};
        STAT_OFS: rdata_r <= {19'h0, stat_r};
        LIVE_OFS: rdata_r <= live_word;
        default:  rdata_r <= 32'h0000_0000;
      endcase
  end

  assign wb_dat_o = rdata_r;
  assign wb_ack_o = ack_r;

endmodule : hbridge_protection_output_control
`default_nettype wire

// file: shared/hbridge_pkg.sv
// constants and register layout for the h-bridge protection and output block
// Summary of operation
// R1 - supply-low comparator qualified only after staying asserted 10 us at least
// R2 - qualified undervoltage tri-states outputs, status low; outputs recover, status stays latched
// R3 - overvoltage comparator held beyond 3.0 us sets supply_high_flag and overvoltage state
// R4 - full-bridge overvoltage drives both outputs high and latches fault_status_n low
// R5 - half-bridge overvoltage leaves the output states unchanged
// R6 - overvoltage recovery restores outputs; flag and status held until a clear
// R7 - temperature warning never stops outputs; its flag is live and self-clearing
// R8 - overtemperature held 11 us latches outputs off, sets thermal_shutdown_flag
// R9 - short or overtemperature latch released by disable/sleep toggle or clear
// R10 - full-bridge short disables both outputs, half-bridge only the shorted one
// R11 - half-bridge: output a follows input one, output b follows input two
// R12 - full-bridge: input two low gives both high, else a=one, b=not one
// R13 - floating inputs read low, floating disable reads high, floating sleep input sleeps
// R14 - outputs driven only with enable bit set, disable low, sleep input high; full-bridge overvoltage braking also drives them with disable high
// R15 - drive source select uses soft inputs instead of the input pins
// R16 - status pin defaults are configurable through the mask register
// R17 - mask bits share status bit positions; a set bit lets that fault assert status
// R18 - supply_high_protect_off set makes overvoltage a warning only
// R19 - half-bridge treats overvoltage as warning and handles shorts per output
// R20 - each filter is a counter restarting whenever its comparator deasserts
// R21 - reset clears latched flags and the latched outputs-off state
package hbridge_pkg;

  // clock and filter timing
  localparam int CLK_PERIOD_NS  = 5;
  localparam int UV_FILT_NS     = 10000;
  localparam int OV_FILT_NS     = 3000;
  localparam int OT_FILT_NS     = 11000;
  localparam int UV_FILT_CYC    = UV_FILT_NS / CLK_PERIOD_NS;
  localparam int OV_FILT_CYC    = OV_FILT_NS / CLK_PERIOD_NS;
  localparam int OT_FILT_CYC    = OT_FILT_NS / CLK_PERIOD_NS;
  localparam int FILT_CNT_W     = 12;

  // register byte offsets
  localparam logic [4:0] CTRL_OFS   = 5'h00;
  localparam logic [4:0] MASK_OFS   = 5'h04;
  localparam logic [4:0] STAT_OFS   = 5'h08;
  localparam logic [4:0] LIVE_OFS   = 5'h0c;

  // control register fields
  localparam int CTRL_SOFT_A  = 0;
  localparam int CTRL_SOFT_B  = 1;
  localparam int CTRL_SRC_SEL = 2;
  localparam int CTRL_FULL    = 3;
  localparam int CTRL_EN      = 4;
  localparam logic [4:0] CTRL_WMASK = 5'h1f;
  localparam logic [4:0] CTRL_RST   = 5'h18;

  // status and mask fields
  localparam int ST_OT      = 0;
  localparam int ST_TW      = 1;
  localparam int ST_SHORT_A = 4;
  localparam int ST_SHORT_B = 5;
  localparam int ST_OV      = 8;
  localparam int ST_UV      = 9;
  localparam int MASK_DOV   = 12;
  localparam logic [12:0] STAT_BITS = 13'h0333;
  localparam logic [12:0] MASK_WMASK = 13'h1333;
  localparam logic [12:0] MASK_RST   = 13'h0331;

  // synchronised pin vector positions
  localparam int PIN_DIS    = 0;
  localparam int PIN_SLEEP  = 1;
  localparam int PIN_IN1    = 2;
  localparam int PIN_IN2    = 3;
  localparam int PIN_UV     = 4;
  localparam int PIN_OV     = 5;
  localparam int PIN_TW     = 6;
  localparam int PIN_OT     = 7;
  localparam int PIN_SC_A   = 8;
  localparam int PIN_SC_B   = 9;
  localparam int PIN_W      = 10;
  // floating-pin levels: disable high, everything else low
  localparam logic [9:0] PIN_RST = 10'h001;

endpackage : hbridge_pkg

// file: shared/det_if.sv
// carrier between a comparator source and its filter
`timescale 1ns/1ps
`default_nettype none
interface det_if;
  logic raw;
  logic qual;
  modport src (output raw, input qual);
  modport flt (input raw, output qual);
endinterface : det_if
`default_nettype wire

// file: design/det_filter.sv
// detector filter: qualifies a comparator after a run of asserted cycles
`timescale 1ns/1ps
`default_nettype none
module det_filter
  import hbridge_pkg::*;
#(
  parameter int TERM = 1
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  det_if.flt        det
);

  localparam logic [FILT_CNT_W-1:0] LAST = FILT_CNT_W'(TERM - 1);

  logic [FILT_CNT_W-1:0] cnt_r;
  logic                  qual_r;

  // R20 restart on deassert
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r  <= '0;
      qual_r <= 1'b0;
    end
    else if (!det.raw)
    begin
      cnt_r  <= '0;
      qual_r <= 1'b0;
    end
    else if (cnt_r == LAST)
      qual_r <= 1'b1;
    else
      cnt_r <= cnt_r + 1'b1;
  end

  assign det.qual = qual_r;

endmodule : det_filter
`default_nettype wire

// file: tb/bridge_monitor.sv
// port-level assertion checker for the bridge control block
`timescale 1ns/1ps
`default_nettype none
module bridge_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic disable_pin,
  input wire logic sleep_release_input,
  input wire logic supply_low_cmp,
  input wire logic temp_shut_cmp,
  input wire logic short_a_cmp,
  input wire logic bridge_output_a_oe,
  input wire logic bridge_output_b_oe,
  input wire logic fault_status_n
);
  logic [3:0]  up_r;
  logic [11:0] uv_run_r;
  logic [11:0] ot_run_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // cycles since reset, saturating
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) up_r <= 4'h0;
    else if (up_r != 4'hf) up_r <= up_r + 4'h1;
  // run length of an asserted supply-low comparator
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) uv_run_r <= 12'h000;
    else if (!supply_low_cmp) uv_run_r <= 12'h000;
    else if (uv_run_r != 12'hfff) uv_run_r <= uv_run_r + 12'h001;
  // run length of an asserted overtemperature comparator
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) ot_run_r <= 12'h000;
    else if (!temp_shut_cmp) ot_run_r <= 12'h000;
    else if (ot_run_r != 12'hfff) ot_run_r <= ot_run_r + 12'h001;
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_sleep_low;
    (!sleep_release_input)[*4];
  endsequence
  sequence s_dis_high;
    (disable_pin && sleep_release_input && up_r == 4'hf)[*4];
  endsequence
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_after_req: assert property (s_req |=> wb_ack_o) else $error("request not acknowledged");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
  a_sleep_hiz: assert property (s_sleep_low |->
    !bridge_output_a_oe && !bridge_output_b_oe && fault_status_n) else $error("sleep not obeyed");
  a_disable_status: assert property (s_dis_high |-> !fault_status_n) else $error("disable status high");
  a_uv_hiz: assert property (uv_run_r > 12'h7da |->
    !bridge_output_a_oe && !bridge_output_b_oe) else $error("undervoltage outputs driven");
  a_ot_latch_off: assert property (ot_run_r > 12'h8a2 |->
    !bridge_output_a_oe && !bridge_output_b_oe) else $error("overtemperature outputs driven");
  a_short_a_off: assert property ($rose(short_a_cmp) |-> ##[1:4] !bridge_output_a_oe)
    else $error("short did not stop output a");
endmodule : bridge_monitor
bind hbridge_protection_output_control bridge_monitor i_mon (.core_clk(core_clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .disable_pin(disable_pin),
  .sleep_release_input(sleep_release_input), .supply_low_cmp(supply_low_cmp),
  .temp_shut_cmp(temp_shut_cmp), .short_a_cmp(short_a_cmp), .bridge_output_a_oe(bridge_output_a_oe),
  .bridge_output_b_oe(bridge_output_b_oe), .fault_status_n(fault_status_n));
`default_nettype wire

// file: tb/host_model.sv
// host controller model driving the control pins
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       core_clk,
  input  wire logic [3:0] pin_req,
  output var  logic       disable_pin,
  output var  logic       sleep_release_input,
  output var  logic       input_one,
  output var  logic       input_two
);
  initial {input_two, input_one, sleep_release_input, disable_pin} = 4'h1;
  // pins move just after the edge, as firmware port writes do
  always @(posedge core_clk)
    {input_two, input_one, sleep_release_input, disable_pin} <= pin_req;
endmodule : host_model
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the bridge protection and output block
`timescale 1ns/1ps
`default_nettype none
module tb
  import hbridge_pkg::*;
;
  logic core_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [4:0] adr = 5'h00;
  logic [31:0] dat = 32'h0, dat_o;
  logic [3:0] pin_req = 4'h1;
  logic dis, slp, in1, in2, oe_a, oe_b, out_a, out_b, fs_n;
  logic uv = 1'b0, ov = 1'b0, tw = 1'b0, ot = 1'b0, sca = 1'b0, scb = 1'b0;
  int fails = 0, tests_run = 0, m, k;
  always #2.5 core_clk = ~core_clk;
  host_model i_host (.core_clk(core_clk), .pin_req(pin_req), .disable_pin(dis),
    .sleep_release_input(slp), .input_one(in1), .input_two(in2));
  hbridge_protection_output_control i_dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .disable_pin(dis), .sleep_release_input(slp), .input_one(in1), .input_two(in2),
    .supply_low_cmp(uv), .supply_high_cmp(ov), .temp_warn_cmp(tw), .temp_shut_cmp(ot),
    .short_a_cmp(sca), .short_b_cmp(scb), .bridge_output_a(out_a), .bridge_output_a_oe(oe_a),
    .bridge_output_b(out_b), .bridge_output_b_oe(oe_b), .fault_status_n(fs_n));
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // one classic bus cycle, held until ack is seen high at an edge
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    if (n >= 40) fails++;
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg
  // compares {oe_a, a, oe_b, b, status}, levels only where driven
  task automatic chk_out(input string nm, input logic [4:0] e);
    logic [4:0] g;
    g = {oe_a, oe_a & out_a, oe_b, oe_b & out_b, fs_n};
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_out
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk_reg(nm, e, q);
  endtask : rd_chk
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_cyc
  task automatic pin(input logic d, input logic s, input logic i1, input logic i2);
    @(posedge core_clk);
    pin_req <= {i2, i1, s, d};
    wait_cyc(8);
  endtask : pin
  function automatic logic [4:0] exp_out(input logic full, input logic i1, input logic i2);
    if (full && !i2) return 5'b11111;
    return {1'b1, i1, 1'b1, full ? !i1 : i2, 1'b1};
  endfunction : exp_out
  // watchdog sized well beyond the longest filter sequence
  initial
  begin
    #300000;
    fails++;
    end_of_test();
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    wait_cyc(6);
    rd_chk("ctrl", CTRL_OFS, 32'h18);
    rd_chk("mask", MASK_OFS, 32'h331);
    rd_chk("status", STAT_OFS, 32'h0);
    wr(5'h10, 32'hffffffff);
    rd_chk("unmapped", 5'h10, 32'h0);
    $display("test reset done");
    for (m = 0; m < 3; m++)
      for (k = 0; k < 4; k++)
      begin
        wr(CTRL_OFS, m == 0 ? 32'h18 : (m == 1 ? 32'h10 : 32'h14 | k));
        pin(1'b0, 1'b1, k[0] ^ (m == 2), k[1] ^ (m == 2));
        chk_out("truth", exp_out(m == 0, k[0], k[1]));
      end
    $display("test truth table done");
    wr(CTRL_OFS, 32'h10);
    pin(1'b1, 1'b1, 1'b1, 1'b0);
    chk_out("disable", 5'b00000);
    pin(1'b0, 1'b0, 1'b1, 1'b0);
    chk_out("sleep", 5'b00001);
    pin(1'b0, 1'b1, 1'b1, 1'b0);
    wr(CTRL_OFS, 32'h00);
    wait_cyc(8);
    chk_out("enable off", 5'b00001);
    wr(CTRL_OFS, 32'h10);
    $display("test enables done");
    @(posedge core_clk);
    uv <= 1'b1;
    wait_cyc(1990);
    chk_out("uv filter", 5'b11101);
    wait_cyc(20);
    chk_out("uv active", 5'b00000);
    @(posedge core_clk);
    uv <= 1'b0;
    wait_cyc(8);
    chk_out("uv recover", 5'b11100);
    rd_chk("uv flag", STAT_OFS, 32'h200);
    wr(STAT_OFS, 32'h200);
    wait_cyc(8);
    chk_out("uv cleared", 5'b11101);
    $display("test undervoltage done");
    for (m = 0; m < 3; m++)
    begin
      wr(CTRL_OFS, m == 1 ? 32'h10 : 32'h18);
      wr(MASK_OFS, m == 2 ? 32'h1331 : 32'h331);
      pin(1'b0, 1'b1, 1'b0, 1'b1);
      @(posedge core_clk);
      ov <= 1'b1;
      wait_cyc(590);
      chk_out("ov filter", 5'b10111);
      wait_cyc(20);
      chk_out("ov active", m == 0 ? 5'b11110 : 5'b10110);
      rd_chk("ov flag", STAT_OFS, 32'h100);
      @(posedge core_clk);
      ov <= 1'b0;
      wait_cyc(8);
      chk_out("ov recover", 5'b10110);
      wr(STAT_OFS, 32'h100);
      wait_cyc(8);
      chk_out("ov cleared", 5'b10111);
    end
    $display("test overvoltage done");
    @(posedge core_clk);
    tw <= 1'b1;
    wait_cyc(8);
    rd_chk("warn set", STAT_OFS, 32'h2);
    chk_out("warn outputs", 5'b10111);
    @(posedge core_clk);
    tw <= 1'b0;
    wait_cyc(8);
    rd_chk("warn gone", STAT_OFS, 32'h0);
    @(posedge core_clk);
    ot <= 1'b1;
    wait_cyc(2190);
    chk_out("ot filter", 5'b10111);
    wait_cyc(30);
    chk_out("ot latched", 5'b00000);
    rd_chk("ot flag", STAT_OFS, 32'h1);
    @(posedge core_clk);
    ot <= 1'b0;
    wait_cyc(8);
    chk_out("ot held", 5'b00000);
    wr(STAT_OFS, 32'h1);
    wait_cyc(8);
    chk_out("ot cleared", 5'b10111);
    $display("test thermal done");
    @(posedge core_clk);
    sca <= 1'b1;
    repeat (2) @(posedge core_clk);
    sca <= 1'b0;
    wait_cyc(8);
    chk_out("short full", 5'b00000);
    pin(1'b1, 1'b1, 1'b0, 1'b1);
    pin(1'b0, 1'b1, 1'b0, 1'b1);
    chk_out("short toggle", 5'b10111);
    wr(CTRL_OFS, 32'h10);
    @(posedge core_clk);
    scb <= 1'b1;
    repeat (2) @(posedge core_clk);
    scb <= 1'b0;
    wait_cyc(8);
    chk_out("short half", 5'b10000);
    rd_chk("short flag", STAT_OFS, 32'h20);
    wr(STAT_OFS, 32'h20);
    wait_cyc(8);
    chk_out("short cleared", 5'b10111);
    rd_chk("live", LIVE_OFS, 32'h0000000a);
    $display("test short done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
